// *** rtl/ext_mode_ctrl.sv ***
/*
 * Extended mode register decode, driver calibration, partial refresh retention
 * and termination control of the memory device.
 * Assumes command pins and data are synchronous to CLK_I (no synchroniser needed)
 * and that each clock carries two data beats, rising then falling.
 */
`include "ext_mode_map.svh"
`default_nettype none

module ext_mode_ctrl
	import ext_mode_pkg::*;
#(
	parameter int         DQ_WIDTH     = 8,
	parameter bit         EIGHT_BANKS  = 1'b1,
	parameter bit         DCC_CONTROL  = 1'b1,
	parameter logic [3:0] DEFAULT_STEP = `RESET_STEP
) (
	// clock and reset
	input  wire logic                CLK_I,
	input  wire logic                RST_N_I,
	// command pins
	input  wire logic                CS_N_I,
	input  wire logic                RAS_N_I,
	input  wire logic                CAS_N_I,
	input  wire logic                WE_N_I,
	input  wire logic                CKE_I,
	input  wire logic [2:0]          BA_I,
	input  wire logic [15:0]         A_I,
	input  wire logic                ODT_I,
	// data in, two beats per clock
	input  wire logic [DQ_WIDTH-1:0] DQ_RISE_I,
	input  wire logic [DQ_WIDTH-1:0] DQ_FALL_I,
	// data and strobe drive
	output logic      [DQ_WIDTH-1:0] DQ_O,
	output logic                     DQ_OE_O,
	output logic                     DQS_O,
	output logic                     DQS_N_O,
	output logic                     RDQS_O,
	output logic                     STROBE_OE_O,
	// driver strength
	output logic      [3:0]          PULLUP_STEP_O,
	output logic      [3:0]          PULLDOWN_STEP_O,
	// refresh control
	output logic      [7:0]          BANK_RETAIN_O,
	output logic                     SELF_REFRESH_O,
	output logic                     HIGH_TEMP_RATE_O,
	output logic                     DUTY_CYCLE_CORRECTOR_O,
	// termination
	output logic      [1:0]          RTT_SEL_O,
	output logic                     TERM_ON_O,
	output logic                     TERM_UPDATE_BUSY_O,
	output logic                     CKE_LOW_IN_UPDATE_O
);

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	cmd_type cmd;
	assign cmd = '{cs_n: CS_N_I, ras_n: RAS_N_I, cas_n: CAS_N_I, we_n: WE_N_I,
	               cke: CKE_I, bank: BA_I, addr: A_I};

	wire logic mode_set  = !cmd.cs_n && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
	wire logic sr_enter  = !cmd.cs_n && !cmd.ras_n && !cmd.cas_n && cmd.we_n && !cmd.cke;
	// bank bit 2 ignored in select; reserved register writes are accepted silently
	wire logic wr_main   = mode_set && (cmd.bank[1:0] == 2'(`SEL_MAIN));
	wire logic wr_first  = mode_set && (cmd.bank[1:0] == 2'(`SEL_FIRST_EXT));
	wire logic wr_ref    = mode_set && (cmd.bank[1:0] == 2'(`SEL_REFRESH_CTRL));
	wire logic [2:0] cal_code = cmd.addr[`FIRST_CAL_LSB +: 3];

	// ----------------------------------------
	// stored fields
	// ----------------------------------------
	logic [2:0] cl_q;
	logic [2:0] bl_q;
	logic [2:0] al_q;
	logic [2:0] partial_q;
	logic       sr_q;
	logic [1:0] rtt_pend_q;

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cl_q      <= `RESET_CL;
			bl_q      <= `RESET_BL;
			al_q      <= 3'h0;
			partial_q <= 3'h0;
			sr_q      <= 1'b0;
		end else begin
			if (wr_main) begin
				cl_q <= cmd.addr[`MAIN_CL_LSB +: 3];
				bl_q <= cmd.addr[`MAIN_BL_LSB +: 3];
			end
			// adjust keeps the additive latency already in force
			if (wr_first && cal_code != `CAL_ADJUST)
				al_q <= cmd.addr[`FIRST_AL_LSB +: 3];
			if (wr_ref)
				partial_q <= cmd.addr[`REF_PARTIAL_LSB +: 3];
			if (sr_enter)
				sr_q <= 1'b1;
			else if (cmd.cke)
				sr_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			HIGH_TEMP_RATE_O       <= 1'b0;
			DUTY_CYCLE_CORRECTOR_O <= 1'b0;
		end else if (wr_ref) begin
			HIGH_TEMP_RATE_O       <= cmd.addr[`REF_HIGH_TEMP_BIT];
			DUTY_CYCLE_CORRECTOR_O <= DCC_CONTROL && cmd.addr[`REF_DCC_BIT];
		end
	end

	// ----------------------------------------
	// partial refresh retention
	// ----------------------------------------
	function automatic logic [7:0] retain_mask(input logic [2:0] code, input logic eight);
		logic [7:0] m;
		m = 8'hff;
		if (eight) begin
			unique case (code)
				3'h0: m = 8'hff;
				3'h1: m = 8'h0f;
				3'h2: m = 8'h03;
				3'h3: m = 8'h01;
				3'h4: m = 8'hfc;
				3'h5: m = 8'hf0;
				3'h6: m = 8'hc0;
				3'h7: m = 8'h80;
			endcase
		end else begin
			unique case (code)
				3'h1: m = 8'h03;
				3'h2: m = 8'h01;
				3'h4: m = 8'h0e;
				3'h5: m = 8'h0c;
				3'h6: m = 8'h08;
				3'h0, 3'h3, 3'h7: m = 8'h0f;
			endcase
		end
		return m;
	endfunction

	wire logic [7:0] all_banks = EIGHT_BANKS ? 8'hff : 8'h0f;
	wire logic [7:0] retain_d  = sr_q ? retain_mask(partial_q, EIGHT_BANKS) : all_banks;

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			BANK_RETAIN_O  <= EIGHT_BANKS ? 8'hff : 8'h0f;
			SELF_REFRESH_O <= 1'b0;
		end else begin
			BANK_RETAIN_O  <= retain_d;
			SELF_REFRESH_O <= sr_q;
		end
	end

	// ----------------------------------------
	// driver calibration
	// ----------------------------------------
	cal_state_type state_q, state_d;
	logic [3:0]    cnt_q, cnt_d;
	logic          level_q, level_d;
	logic [1:0]    beat01_q;

	// write latency of the code burst: additive plus column minus one
	wire logic [3:0] wl = 4'({1'b0, al_q} + {1'b0, cl_q} - 4'h1);
	wire logic [3:0] oit = 4'(`OIT_CYCLES);
	// every data line carries the same code, so lane zero suffices
	wire logic [3:0] code = {beat01_q[0], beat01_q[1], DQ_RISE_I[0], DQ_FALL_I[0]};
	wire logic is_drive = (cal_code == `CAL_DRIVE_HIGH) || (cal_code == `CAL_DRIVE_LOW);

	always_comb begin
		state_d = state_q;
		cnt_d   = (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
		level_d = level_q;
		unique case (state_q)
			CAL_TO_ON:  if (cnt_q == 4'h1) state_d = CAL_DRIVE;
			CAL_TO_OFF: if (cnt_q == 4'h1) state_d = CAL_IDLE;
			CAL_WAIT:   if (cnt_q == 4'h1) state_d = CAL_BEAT23;
			CAL_BEAT23: state_d = CAL_HOLD;
			CAL_IDLE, CAL_DRIVE, CAL_HOLD: ;
			default:    state_d = CAL_IDLE;
		endcase
		if (wr_first) begin
			unique case (cal_code)
				`CAL_DRIVE_HIGH, `CAL_DRIVE_LOW: begin
					state_d = CAL_TO_ON;
					cnt_d   = oit;
					level_d = (cal_code == `CAL_DRIVE_HIGH);
				end
				`CAL_ADJUST: begin
					// zero latency: beats zero and one arrive with the command
					state_d = (wl == 4'h0) ? CAL_BEAT23 : CAL_WAIT;
					cnt_d   = wl;
				end
				`CAL_EXIT: begin
					state_d = (state_q == CAL_DRIVE || state_q == CAL_TO_ON) ?
					          CAL_TO_OFF : CAL_IDLE;
					cnt_d   = oit;
				end
				default: state_d = CAL_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_q  <= CAL_IDLE;
			cnt_q    <= 4'h0;
			level_q  <= 1'b0;
			beat01_q <= 2'h0;
		end else begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			level_q  <= level_d;
			beat01_q <= {DQ_FALL_I[0], DQ_RISE_I[0]};
		end
	end

	// ----------------------------------------
	// strength steps
	// ----------------------------------------
	step_type inc, dec;
	wire logic apply   = (state_q == CAL_BEAT23);
	wire logic restore = wr_first && (cal_code == `CAL_DEFAULT);

	always_comb begin
		inc = '0;
		dec = '0;
		if (apply) begin
			unique case (code)
				4'b0001: inc.up = 1'b1;
				4'b0010: dec.up = 1'b1;
				4'b0100: inc.down = 1'b1;
				4'b1000: dec.down = 1'b1;
				4'b0101: inc = '{up: 1'b1, down: 1'b1};
				4'b0110: begin dec.up = 1'b1; inc.down = 1'b1; end
				4'b1001: begin inc.up = 1'b1; dec.down = 1'b1; end
				4'b1010: dec = '{up: 1'b1, down: 1'b1};
				default: ; // reserved codes act as no-op
			endcase
		end
	end

	// one counter pair serves every data and strobe driver
	drive_step #(.STEPS(16), .DEFAULT(DEFAULT_STEP)) u_pullup (
		.clk_i     (CLK_I),
		.rst_n_i   (RST_N_I),
		.inc_i     (inc.up),
		.dec_i     (dec.up),
		.restore_i (restore),
		.step_o    (PULLUP_STEP_O)
	);

	drive_step #(.STEPS(16), .DEFAULT(DEFAULT_STEP)) u_pulldown (
		.clk_i     (CLK_I),
		.rst_n_i   (RST_N_I),
		.inc_i     (inc.down),
		.dec_i     (dec.down),
		.restore_i (restore),
		.step_o    (PULLDOWN_STEP_O)
	);

	// ----------------------------------------
	// drive outputs
	// ----------------------------------------
	// keep driving through the turn-off delay, but only if already driving
	wire logic drive_on = (state_d == CAL_DRIVE) || (state_d == CAL_TO_OFF && DQ_OE_O);

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			DQ_O        <= '0;
			DQ_OE_O     <= 1'b0;
			DQS_O       <= 1'b0;
			DQS_N_O     <= 1'b0;
			RDQS_O      <= 1'b0;
			STROBE_OE_O <= 1'b0;
		end else begin
			DQ_O        <= {DQ_WIDTH{level_d}};
			DQ_OE_O     <= drive_on;
			DQS_O       <= level_d;
			DQS_N_O     <= !level_d;
			RDQS_O      <= level_d;
			STROBE_OE_O <= drive_on;
		end
	end

	// ----------------------------------------
	// termination
	// ----------------------------------------
	logic [3:0] mod_cnt_q;
	wire logic  upd_start = wr_first && !is_drive && cal_code != `CAL_ADJUST;
	wire logic  mod_min   = (mod_cnt_q == 4'(`MOD_MAX_CYCLES - `MOD_MIN_CYCLES + 1));

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rtt_pend_q          <= 2'h0;
			mod_cnt_q           <= 4'h0;
			RTT_SEL_O           <= 2'h0;
			TERM_ON_O           <= 1'b0;
			TERM_UPDATE_BUSY_O  <= 1'b0;
			CKE_LOW_IN_UPDATE_O <= 1'b0;
		end else begin
			if (upd_start) begin
				rtt_pend_q <= {cmd.addr[`FIRST_RTT_HI], cmd.addr[`FIRST_RTT_LO]};
				mod_cnt_q  <= 4'(`MOD_MAX_CYCLES);
			end else if (mod_cnt_q != 4'h0) begin
				mod_cnt_q <= mod_cnt_q - 4'h1;
			end
			if (mod_min)
				RTT_SEL_O <= rtt_pend_q;
			TERM_UPDATE_BUSY_O <= upd_start || (mod_cnt_q > 4'h1);
			// sticky: a later update clears it, a new violation in that cycle wins
			if (TERM_UPDATE_BUSY_O && !cmd.cke)
				CKE_LOW_IN_UPDATE_O <= 1'b1;
			else if (upd_start)
				CKE_LOW_IN_UPDATE_O <= 1'b0;
			TERM_ON_O <= ODT_I && !sr_q && !sr_enter && (RTT_SEL_O != 2'h0);
		end
	end

endmodule

`default_nettype wire

// *** rtl/ext_mode_map.svh ***
/*
 * Offsets, field positions, codes and timing constants for the extended mode logic.
 * Assumes the includer runs on a single 4 ns command clock.
 */
`ifndef EXT_MODE_MAP_SVH
`define EXT_MODE_MAP_SVH

// ----------------------------------------
// register select by bank bits
// ----------------------------------------
`define SEL_MAIN          3'h0
`define SEL_FIRST_EXT     3'h1
`define SEL_REFRESH_CTRL  3'h2
`define SEL_RESERVED3     3'h3

// ----------------------------------------
// field positions
// ----------------------------------------
`define MAIN_BL_LSB       0
`define MAIN_CL_LSB       4
`define FIRST_RTT_LO      2
`define FIRST_AL_LSB      3
`define FIRST_RTT_HI      6
`define FIRST_CAL_LSB     7
`define REF_PARTIAL_LSB   0
`define REF_DCC_BIT       3
`define REF_HIGH_TEMP_BIT 7

// ----------------------------------------
// calibration field codes
// ----------------------------------------
`define CAL_EXIT          3'h0
`define CAL_DRIVE_HIGH    3'h1
`define CAL_DRIVE_LOW     3'h2
`define CAL_ADJUST        3'h4
`define CAL_DEFAULT       3'h7

// ----------------------------------------
// reset values
// ----------------------------------------
`define RESET_CL          3'h3
`define RESET_BL          3'h2
`define RESET_STEP        4'h8

// ----------------------------------------
// timing, figures in ns at 4 ns per clock
// ----------------------------------------
`define CLK_PERIOD_NS     4
`define OIT_MAX_NS        12
`define MOD_MIN_NS        0
`define MOD_MAX_NS        12
`define OIT_CYCLES        ((`OIT_MAX_NS / `CLK_PERIOD_NS) < 1 ? 1 : (`OIT_MAX_NS / `CLK_PERIOD_NS))
`define MOD_MIN_CYCLES    (((`MOD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                           ((`MOD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define MOD_MAX_CYCLES    ((`MOD_MAX_NS / `CLK_PERIOD_NS) < 1 ? 1 : (`MOD_MAX_NS / `CLK_PERIOD_NS))

`endif

// *** rtl/ext_mode_pkg.sv ***
/*
 * Types shared by the extended mode logic.
 * Assumes ext_mode_map.svh supplies all numeric constants.
 */
`default_nettype none

package ext_mode_pkg;

	typedef enum logic [2:0] {
		CAL_IDLE   = 3'b000,
		CAL_TO_ON  = 3'b001,
		CAL_DRIVE  = 3'b010,
		CAL_TO_OFF = 3'b011,
		CAL_WAIT   = 3'b100,
		CAL_BEAT23 = 3'b101,
		CAL_HOLD   = 3'b110
	} cal_state_type;

	typedef struct packed {
		logic       cs_n;
		logic       ras_n;
		logic       cas_n;
		logic       we_n;
		logic       cke;
		logic [2:0] bank;
		logic [15:0] addr;
	} cmd_type;

	typedef struct packed {
		logic       up;
		logic       down;
	} step_type;

endpackage

`default_nettype wire

// *** rtl/drive_step.sv ***
/*
 * Saturating driver strength counter, one per pull direction.
 * Assumes inc and dec are never both high.
 */
`default_nettype none

module drive_step #(
	parameter int         STEPS   = 16,
	parameter logic [3:0] DEFAULT = 4'h8
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// step requests
	input  wire logic       inc_i,
	input  wire logic       dec_i,
	input  wire logic       restore_i,
	// strength
	output logic      [3:0] step_o
);

	wire logic at_top = (step_o == 4'(STEPS - 1));
	wire logic at_bot = (step_o == 4'h0);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			step_o <= 4'h8;
		else if (restore_i)
			step_o <= DEFAULT;
		else if (inc_i && !at_top)
			step_o <= step_o + 4'h1;
		else if (dec_i && !at_bot)
			step_o <= step_o - 4'h1;
	end

endmodule

`default_nettype wire

// *** testbench/ext_mode_properties.sv ***
/* Port assertions for the extended mode block.
   Assumes a bind by name onto ext_mode_ctrl and one command clock. */
`default_nettype none

module ext_mode_properties #(
	parameter int DQ_WIDTH    = 8,
	parameter bit EIGHT_BANKS = 1'b1,
	parameter bit DCC_CONTROL = 1'b1
) (
	// clock and reset
	input wire logic                CLK_I,
	input wire logic                RST_N_I,
	// command side
	input wire logic                CS_N_I,
	input wire logic                RAS_N_I,
	input wire logic                CAS_N_I,
	input wire logic                WE_N_I,
	input wire logic                CKE_I,
	input wire logic [2:0]          BA_I,
	input wire logic [15:0]         A_I,
	input wire logic                ODT_I,
	// device side
	input wire logic [DQ_WIDTH-1:0] DQ_O,
	input wire logic                DQ_OE_O,
	input wire logic                DQS_O,
	input wire logic                DQS_N_O,
	input wire logic                RDQS_O,
	input wire logic [3:0]          PULLUP_STEP_O,
	input wire logic [3:0]          PULLDOWN_STEP_O,
	input wire logic [7:0]          BANK_RETAIN_O,
	input wire logic                SELF_REFRESH_O,
	input wire logic                HIGH_TEMP_RATE_O,
	input wire logic                DUTY_CYCLE_CORRECTOR_O,
	input wire logic [1:0]          RTT_SEL_O,
	input wire logic                TERM_ON_O,
	input wire logic                TERM_UPDATE_BUSY_O,
	input wire logic                CKE_LOW_IN_UPDATE_O
);
	// ----------------
	// decode
	// ----------------
	wire logic mset  = !CS_N_I && !RAS_N_I && !CAS_N_I && !WE_N_I;
	wire logic first = mset && BA_I[1:0] == 2'h1;

	default clocking dc @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	AST_DRV_ON: assert property (first && A_I[9:7] == 3'h1 && !DQ_OE_O |=>
		!DQ_OE_O [*2] ##2 (DQ_OE_O && DQ_O == '1)) else $error("drive start late or early");
	AST_DRV_LVL: assert property (DQ_OE_O |->
		DQS_N_O == !DQS_O && RDQS_O == DQS_O && DQ_O == {DQ_WIDTH{DQS_O}}) else $error("bad levels");
	AST_DRV_OFF: assert property (first && A_I[9:7] == 3'h0 && DQ_OE_O |=>
		DQ_OE_O [*2] ##2 !DQ_OE_O) else $error("drive stop late or early");
	AST_REF_BITS: assert property (mset && BA_I[1:0] == 2'h2 |=>
		HIGH_TEMP_RATE_O == $past(A_I[7]) &&
		DUTY_CYCLE_CORRECTOR_O == (DCC_CONTROL && $past(A_I[3])))
		else $error("refresh bits wrong");
	AST_RSV3: assert property (mset && BA_I[1:0] == 2'h3 |=> $stable(HIGH_TEMP_RATE_O) &&
		$stable(DUTY_CYCLE_CORRECTOR_O) && $stable(BANK_RETAIN_O)) else $error("reg three acted");
	AST_TERM_SR: assert property (SELF_REFRESH_O && !CKE_I |=> !TERM_ON_O)
		else $error("termination on in self refresh");
	AST_TERM_ON: assert property (ODT_I && CKE_I && $past(CKE_I) && !SELF_REFRESH_O &&
		RTT_SEL_O != 2'h0 |=> TERM_ON_O) else $error("termination stayed off");
	AST_RETAIN: assert property (!SELF_REFRESH_O && !$past(SELF_REFRESH_O) |->
		BANK_RETAIN_O == (EIGHT_BANKS ? 8'hff : 8'h0f)) else $error("banks lost outside self refresh");
	AST_SAT_TOP: assert property (PULLUP_STEP_O == 4'hf |=> PULLUP_STEP_O != 4'h0)
		else $error("pull-up wrapped");
	AST_SAT_BOT: assert property (PULLDOWN_STEP_O == 4'h0 |=> PULLDOWN_STEP_O != 4'hf)
		else $error("pull-down wrapped");
	AST_BUSY: assert property (first && A_I[9:7] == 3'h0 |-> ##[1:2] TERM_UPDATE_BUSY_O)
		else $error("no update window");
	AST_CKE_FLAG: assert property (TERM_UPDATE_BUSY_O && !CKE_I |=> CKE_LOW_IN_UPDATE_O)
		else $error("clock enable drop missed");
endmodule

`default_nettype wire

// *** testbench/mem_ctrl_model.sv ***
/* Behavioural memory controller: command pins, termination pin, data beats.
   Assumes the device samples on the rising edge; all drives land 1 ns after it. */
`include "ext_mode_map.svh"
`default_nettype none

module mem_ctrl_model
	import ext_mode_pkg::*;
(
	// clock
	input  wire logic      clk_i,
	// toward the device
	output var cmd_type    cmd_o,
	output var logic       odt_o,
	output var logic [7:0] rise_o,
	output var logic [7:0] fall_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] first_image;  // first ext image with a zero calibration field

	initial begin
		cmd_o = {5'h1f, 19'h0};
		odt_o = 1'b0;
		rise_o = 8'h00;
		fall_o = 8'h00;
		first_image = 16'h0000;
	end

	// ----------------
	// commands
	// ----------------
	// deselect shows the inverted address, so stale bits never pass for valid ones
	task automatic mset(input logic [2:0] ba, input logic [15:0] a);
		@(posedge clk_i);
		#1;
		cmd_o = {4'h0, 1'b1, ba, a};
		@(posedge clk_i);
		#1;
		cmd_o = {5'h1f, ba, ~a};
	endtask

	task automatic cal(input logic [2:0] code);
		mset(3'h1, first_image | {6'h00, code, 7'h00});
	endtask

	task automatic sref(input logic enter);
		@(posedge clk_i);
		#1;
		cmd_o = enter ? {4'h1, 1'b0, 19'h0} : {5'h1f, 19'h0};
		@(posedge clk_i);
		#1;
		cmd_o.cs_n = 1'b1;
	endtask

	// burst length four already set; beats land on the write latency edge
	task automatic adjust(input logic [3:0] code, input int wl);
		cal(`CAL_ADJUST);
		repeat (wl - 1) @(posedge clk_i);
		#1;
		rise_o = {8{code[3]}};  // same beat on every line
		fall_o = {8{code[2]}};  // first beat first, whatever the burst type
		@(posedge clk_i);
		#1;
		rise_o = {8{code[1]}};
		fall_o = {8{code[0]}};
		@(posedge clk_i);
		#1;
		rise_o = ~rise_o;
		fall_o = ~fall_o;
		cal(`CAL_EXIT);
	endtask
endmodule

`default_nettype wire

// *** testbench/tb_ext_mode_ctrl.sv ***
/* Top bench: partner controller, design, bound checker and the verdict.
   Assumes package, map header, design and checker are compiled first. */
`include "ext_mode_map.svh"
`default_nettype none

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_ext_mode_ctrl
	import ext_mode_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] KEEP8 [8] = '{8'hff, 8'h0f, 8'h03, 8'h01, 8'hfc, 8'hf0, 8'hc0, 8'h80};
	localparam logic [7:0] KEEP4 [8] = '{8'h0f, 8'h03, 8'h01, 8'h0f, 8'h0e, 8'h0c, 8'h08, 8'h0f};
	localparam logic [3:0] ADJ [19] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1,
		4'h4, 4'h4, 4'h0, 4'h2, 4'h8, 4'h5, 4'h6, 4'h9, 4'ha, 4'h3, 4'hf};

	logic       clk, rst_n, odt, dq_oe, str_oe, dqs, dqs_n, rdqs, sr, ht, dcc, term_on, busy;
	logic       cke_low;
	logic       dcc4;
	logic [7:0] retain4;
	logic [7:0] rise, fall, dq, retain;
	logic [3:0] up, dn, eu, ed, adj;
	logic [2:0] code;
	logic [1:0] rtt;
	cmd_type    cmd;
	int         err_total = 0;
	int         n_tests = 0;

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	mem_ctrl_model ctl (.clk_i(clk), .cmd_o(cmd), .odt_o(odt), .rise_o(rise), .fall_o(fall));

	ext_mode_ctrl uut (.CLK_I(clk), .RST_N_I(rst_n), .CS_N_I(cmd.cs_n), .RAS_N_I(cmd.ras_n),
		.CAS_N_I(cmd.cas_n), .WE_N_I(cmd.we_n), .CKE_I(cmd.cke), .BA_I(cmd.bank),
		.A_I(cmd.addr), .ODT_I(odt), .DQ_RISE_I(rise), .DQ_FALL_I(fall), .DQ_O(dq),
		.DQ_OE_O(dq_oe), .DQS_O(dqs), .DQS_N_O(dqs_n), .RDQS_O(rdqs), .STROBE_OE_O(str_oe),
		.PULLUP_STEP_O(up), .PULLDOWN_STEP_O(dn), .BANK_RETAIN_O(retain),
		.SELF_REFRESH_O(sr), .HIGH_TEMP_RATE_O(ht), .DUTY_CYCLE_CORRECTOR_O(dcc),
		.RTT_SEL_O(rtt), .TERM_ON_O(term_on), .TERM_UPDATE_BUSY_O(busy),
		.CKE_LOW_IN_UPDATE_O(cke_low));

	// four-bank part without corrector control, same command stream
	ext_mode_ctrl #(.EIGHT_BANKS(1'b0), .DCC_CONTROL(1'b0)) uut4 (.CLK_I(clk), .RST_N_I(rst_n),
		.CS_N_I(cmd.cs_n), .RAS_N_I(cmd.ras_n), .CAS_N_I(cmd.cas_n), .WE_N_I(cmd.we_n),
		.CKE_I(cmd.cke), .BA_I(cmd.bank), .A_I(cmd.addr), .ODT_I(odt), .DQ_RISE_I(rise),
		.DQ_FALL_I(fall), .DQ_O(), .DQ_OE_O(), .DQS_O(), .DQS_N_O(), .RDQS_O(), .STROBE_OE_O(),
		.PULLUP_STEP_O(), .PULLDOWN_STEP_O(), .BANK_RETAIN_O(retain4), .SELF_REFRESH_O(),
		.HIGH_TEMP_RATE_O(), .DUTY_CYCLE_CORRECTOR_O(dcc4), .RTT_SEL_O(), .TERM_ON_O(),
		.TERM_UPDATE_BUSY_O(), .CKE_LOW_IN_UPDATE_O());

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------
	// tests
	// ----------------
	initial begin
		rst_n = 1'b0;
		wait_cyc(8);
		rst_n = 1'b1;
		`CHK({up, dn, retain, dq_oe}, {8'h88, 8'hff, 1'b0})
		`CHK(retain4, 8'h0f)
		ctl.mset(3'h0, 16'h0032);  // column latency 3, burst length 4
		ctl.first_image = 16'h000c;  // additive latency 1, termination code 01
		ctl.cal(`CAL_EXIT);
		ctl.mset(3'h3, 16'h0000);
		wait_cyc(4);
		`CHK(rtt, 2'h1)
		$display("test setup done");
		ctl.odt_o = 1'b1;
		for (int i = 0; i < 8; i++) begin
			code = i[2:0];
			ctl.mset(3'h2, {8'h00, code[0], 3'h0, code[1], code});
			`CHK({ht, dcc}, {code[0], code[1]})
			`CHK(dcc4, 1'b0)
			ctl.sref(1'b1);
			wait_cyc(3);
			`CHK({retain, sr, term_on}, {KEEP8[i], 2'h2})
			`CHK(retain4, KEEP4[i])
			ctl.sref(1'b0);
			wait_cyc(3);
			`CHK({retain, term_on}, 9'h1ff)
			`CHK(retain4, 8'h0f)
		end
		ctl.mset(3'h2, 16'h0000);
		`CHK({ht, dcc}, 2'h0)
		ctl.odt_o = 1'b0;
		wait_cyc(3);
		$display("test refresh done");
		for (int i = 1; i < 3; i++) begin
			code = i[2:0];
			ctl.cal(code);
			wait_cyc(5);
			`CHK({dq_oe, str_oe, dq, dqs, dqs_n, rdqs}, {2'h3, {8{code[0]}}, code[0], code[1], code[0]})
			ctl.cal(`CAL_EXIT);
			wait_cyc(5);
			`CHK({dq_oe, str_oe}, 2'h0)
		end
		$display("test drive done");
		eu = `RESET_STEP;
		ed = `RESET_STEP;
		for (int i = 0; i < 29; i++) begin
			adj = (i < 19) ? ADJ[i] : 4'ha;
			ctl.adjust(adj, 3);
			if (adj inside {4'h1, 4'h5, 4'h9} && eu != 4'hf) eu++;
			if (adj inside {4'h2, 4'h6, 4'ha} && eu != 4'h0) eu--;
			if (adj inside {4'h4, 4'h5, 4'h6} && ed != 4'hf) ed++;
			if (adj inside {4'h8, 4'h9, 4'ha} && ed != 4'h0) ed--;
			wait_cyc(2);
			`CHK({up, dn}, {eu, ed})
		end
		ctl.cal(`CAL_DEFAULT);
		wait_cyc(2);
		`CHK({up, dn}, 8'h88)
		ctl.cal(`CAL_EXIT);
		$display("test adjust done");
		ctl.first_image = 16'h0048;
		ctl.cal(`CAL_EXIT);  // termination pin kept low here
		`CHK(busy, 1'b1)
		ctl.cmd_o.cke = 1'b0;  // dropped inside the window on purpose
		wait_cyc(2);
		ctl.cmd_o.cke = 1'b1;
		wait_cyc(3);
		`CHK({rtt, cke_low, busy}, 4'ha)
		$display("test termination done");
		end_sim();
	end

	initial begin
		wait_cyc(5000);
		err_total++;
		end_sim();
	end
endmodule

bind ext_mode_ctrl ext_mode_properties #(.DQ_WIDTH(DQ_WIDTH), .EIGHT_BANKS(EIGHT_BANKS),
	.DCC_CONTROL(DCC_CONTROL)) chk (.*);

`default_nettype wire
